// ==== hdl/rlds_regs.svh ====
`ifndef RLDS_REGS_SVH
`define RLDS_REGS_SVH

// ==========================================
// link geometry
`define RLDS_SLOT_W 7
`define RLDS_HALF_W 4
`define RLDS_LANES_MAX 4
`define RLDS_LANES_18 3
`define RLDS_LANES_24 4

// ==========================================
// regenerated clock word, bit 0 sent first
`define RLDS_CLK_WORD 7'h63

// ==========================================
// reset and idle values
`define RLDS_RST_BIT 1'h0
`define RLDS_IDLE_POS 1'h0
`define RLDS_IDLE_NEG 1'h1

`endif

// ==== hdl/rlds_pkg.sv ====
`include "rlds_regs.svh"

package rlds_pkg;

    // ==========================================
    // parallel pixel as presented by the source
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic hsync;
        logic vsync;
        logic de;
    } rlds_pixel_t;

    // ==========================================
    // data handed to one ddr differential output
    typedef struct packed {
        logic pos_rise;
        logic pos_fall;
        logic neg_rise;
        logic neg_fall;
    } rlds_ddr_t;

    typedef logic [`RLDS_SLOT_W-1:0] rlds_word_t;
    typedef logic [`RLDS_HALF_W-1:0] rlds_half_t;
    // data lanes plus the clock lane at the top index
    typedef rlds_word_t [`RLDS_LANES_MAX:0] rlds_bank_t;
    typedef rlds_half_t [`RLDS_LANES_MAX:0] rlds_halves_t;

    // ==========================================
    // bit position ring, two pixels per turn
    typedef enum logic [6:0] {
        POS_0 = 7'h01,
        POS_1 = 7'h02,
        POS_2 = 7'h04,
        POS_3 = 7'h08,
        POS_4 = 7'h10,
        POS_5 = 7'h20,
        POS_6 = 7'h40
    } rlds_pos_t;

endpackage : rlds_pkg

// ==== hdl/rlds_ser.sv ====
`timescale 1ns/1ns
`include "rlds_regs.svh"

module rlds_ser (
    // serializer clock and reset
    input wire logic ser_clk_in,
    input wire logic ser_rst_n_in,
    // rising-edge half word, load one cycle ahead
    input wire logic rise_load_in,
    input wire rlds_pkg::rlds_half_t rise_half_in,
    // falling-edge half word, pre-load one cycle ahead
    input wire logic pre_load_180_in,
    input wire rlds_pkg::rlds_half_t fall_half_in,
    // ddr launch data
    output rlds_pkg::rlds_ddr_t ddr_out
);
    import rlds_pkg::*;

    rlds_half_t rise_reg, rise_next, rise_n_reg, rise_n_next;
    rlds_half_t fall_reg, fall_next, fall_n_reg, fall_n_next;
    rlds_half_t half_180_reg;
    logic load_180_reg;

    // ==========================================
    // rising-edge shift register
    always_comb begin
        if (rise_load_in) begin
            rise_next = rise_half_in;
            rise_n_next = ~rise_half_in;
        end else begin
            rise_next = rise_reg >> 1;
            rise_n_next = {`RLDS_IDLE_NEG, rise_n_reg[`RLDS_HALF_W-1:1]};
        end
    end

    always_ff @(posedge ser_clk_in) begin
        if (!ser_rst_n_in) begin
            rise_reg <= '0;
            rise_n_reg <= '1;
        end else begin
            rise_reg <= rise_next;
            rise_n_reg <= rise_n_next;
        end
    end

    // ==========================================
    // falling-edge shift register
    // the load is re-clocked onto this edge so it is stable a full cycle before use
    always_comb begin
        if (load_180_reg) begin
            fall_next = half_180_reg;
            fall_n_next = ~half_180_reg;
        end else begin
            fall_next = fall_reg >> 1;
            fall_n_next = {`RLDS_IDLE_NEG, fall_n_reg[`RLDS_HALF_W-1:1]};
        end
    end

    always_ff @(negedge ser_clk_in) begin
        if (!ser_rst_n_in) begin
            load_180_reg <= `RLDS_RST_BIT;
            half_180_reg <= '0;
            fall_reg <= '0;
            fall_n_reg <= '1;
        end else begin
            load_180_reg <= pre_load_180_in;
            half_180_reg <= fall_half_in;
            fall_reg <= fall_next;
            fall_n_reg <= fall_n_next;
        end
    end

    assign ddr_out = '{pos_rise: rise_reg[0], pos_fall: fall_reg[0],
                       neg_rise: rise_n_reg[0], neg_fall: fall_n_reg[0]};

    // ==========================================
    // checks
    AST_NEG_RISE: assert property (@(posedge ser_clk_in) disable iff (!ser_rst_n_in)
        ddr_out.neg_rise != ddr_out.pos_rise)
        else $error("negative pin not inverse on rising edge");

    AST_NEG_FALL: assert property (@(negedge ser_clk_in) disable iff (!ser_rst_n_in)
        ddr_out.neg_fall != ddr_out.pos_fall)
        else $error("negative pin not inverse on falling edge");

    AST_LOAD_180: assert property (@(negedge ser_clk_in) disable iff (!ser_rst_n_in)
        pre_load_180_in |=> ##1 (ddr_out.pos_fall == $past(fall_half_in[0], 2)))
        else $error("falling-edge load not taken one edge after pre-load");

endmodule : rlds_ser

// ==== hdl/rlds_tx.sv ====
`timescale 1ns/1ns
`include "rlds_regs.svh"


module rlds_tx #(
    parameter int LANES = `RLDS_LANES_18
) (
    // pixel clock domain
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // parallel pixel input
    input wire rlds_pkg::rlds_pixel_t pixel_in,
    // serializer clock from the pll
    input wire logic ser_clk_in,
    // ddr launch data for the differential outputs
    output rlds_pkg::rlds_ddr_t [`RLDS_LANES_MAX-1:0] lane_out,
    output rlds_pkg::rlds_ddr_t link_clock_out
);
    import rlds_pkg::*;

    // ==========================================
    // helper functions

    // lane mapping; bit 0 of each word is sent first
    function automatic rlds_bank_t lvds_format(input rlds_pixel_t p);
        rlds_bank_t b;
        b[0] = {p.green[0], p.red[5:0]};
        b[1] = {p.blue[1:0], p.green[5:1]};
        b[2] = {p.de, p.vsync, p.hsync, p.blue[5:2]};
        // spare slot of lane 3 is the 28th signal; sent as zero
        b[3] = {`RLDS_RST_BIT, p.blue[7:6], p.green[7:6], p.red[7:6]};
        b[`RLDS_LANES_MAX] = `RLDS_CLK_WORD;
        return b;
    endfunction : lvds_format

    // bits 0,2,4,6 in order
    function automatic rlds_half_t even_bits(input rlds_word_t w);
        rlds_half_t h;
        for (int i = 0; i < `RLDS_HALF_W; i++) begin
            h[i] = w[2 * i];
        end
        return h;
    endfunction : even_bits

    // bits 1,3,5 in order, top slot padded
    function automatic rlds_half_t odd_bits(input rlds_word_t w);
        rlds_half_t h;
        h = '0;
        for (int i = 0; i < `RLDS_HALF_W - 1; i++) begin
            h[i] = w[2 * i + 1];
        end
        return h;
    endfunction : odd_bits

    // ==========================================
    // pixel clock domain: capture and hand-over

    rlds_pixel_t pix_reg, pix_next;
    rlds_bank_t xfer_reg, xfer_next;
    logic req_reg, req_next;
    logic ack_s1_reg, ack_s2_reg;
    logic req_s3_reg;

    always_comb begin
        pix_next = pixel_in;
        xfer_next = xfer_reg;
        req_next = req_reg;
        // a new word is offered only once the last one was taken, so the
        // word never moves while the far side may be sampling it
        if (req_reg == ack_s2_reg) begin
            xfer_next = lvds_format(pix_reg);
            req_next = ~req_reg;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            pix_reg <= '0;
            xfer_reg <= '0;
            req_reg <= `RLDS_RST_BIT;
            ack_s1_reg <= `RLDS_RST_BIT;
            ack_s2_reg <= `RLDS_RST_BIT;
        end else begin
            pix_reg <= pix_next;
            xfer_reg <= xfer_next;
            req_reg <= req_next;
            ack_s1_reg <= req_s3_reg;
            ack_s2_reg <= ack_s1_reg;
        end
    end

    // ==========================================
    // serializer domain: reset and request synchronisers

    logic rst_s1_reg, rst_s2_reg;
    logic req_s1_reg, req_s2_reg;
    rlds_bank_t latest_reg, latest_next;
    logic seen_reg, seen_next;

    always_ff @(posedge ser_clk_in) begin
        rst_s1_reg <= reset_n_in;
        rst_s2_reg <= rst_s1_reg;
    end

    always_comb begin
        latest_next = latest_reg;
        seen_next = seen_reg;
        if (req_s2_reg != req_s3_reg) begin
            latest_next = xfer_reg;
            seen_next = 1'b1;
        end
    end

    // limitation: each hand-over needs a full req/ack round trip at any clock ratio, so
    // pixels arriving between hand-overs are dropped, never torn
    always_ff @(posedge ser_clk_in) begin
        if (!rst_s2_reg) begin
            req_s1_reg <= `RLDS_RST_BIT;
            req_s2_reg <= `RLDS_RST_BIT;
            req_s3_reg <= `RLDS_RST_BIT;
            latest_reg <= '0;
            seen_reg <= `RLDS_RST_BIT;
        end else begin
            req_s1_reg <= req_reg;
            req_s2_reg <= req_s1_reg;
            req_s3_reg <= req_s2_reg;
            latest_reg <= latest_next;
            seen_reg <= seen_next;
        end
    end

    // ==========================================
    // output control generator: bit position ring and load decode

    rlds_pos_t pos_reg, pos_next;
    logic rise_load_reg, rise_load_next;
    logic pre_load_reg, pre_load_next;
    rlds_halves_t rise_half_reg, rise_half_next;
    rlds_halves_t fall_half_reg, fall_half_next;
    rlds_bank_t hold_b_reg, hold_b_next;
    logic primed_reg, primed_next;

    // one turn of seven fast cycles carries two pixels of seven bits
    always_comb begin
        case (pos_reg)
            POS_0: pos_next = POS_1;
            POS_1: pos_next = POS_2;
            POS_2: pos_next = POS_3;
            POS_3: pos_next = POS_4;
            POS_4: pos_next = POS_5;
            POS_5: pos_next = POS_6;
            POS_6: pos_next = POS_0;
            default: pos_next = POS_0;
        endcase
    end

    // loads are decoded a cycle ahead so every control is a flop at use
    always_comb begin
        rise_load_next = (pos_reg == POS_5) || (pos_reg == POS_2);
        pre_load_next = (pos_reg == POS_5) || (pos_reg == POS_1);
        rise_half_next = rise_half_reg;
        fall_half_next = fall_half_reg;
        hold_b_next = hold_b_reg;
        primed_next = primed_reg | (seen_reg && (pos_reg == POS_5));
        for (int k = 0; k <= `RLDS_LANES_MAX; k++) begin
            case (pos_reg)
                POS_5: begin
                    // first pixel: evens on rising edge, odds on falling
                    rise_half_next[k] = even_bits(latest_reg[k]);
                    fall_half_next[k] = odd_bits(latest_reg[k]);
                end
                POS_1: begin
                    // second pixel starts on a falling edge, so roles swap
                    hold_b_next[k] = latest_reg[k];
                    fall_half_next[k] = even_bits(latest_reg[k]);
                end
                POS_2: begin
                    rise_half_next[k] = odd_bits(hold_b_reg[k]);
                end
                default: begin
                    rise_half_next[k] = rise_half_reg[k];
                end
            endcase
        end
    end

    always_ff @(posedge ser_clk_in) begin
        if (!rst_s2_reg) begin
            pos_reg <= POS_0;
            rise_load_reg <= `RLDS_RST_BIT;
            pre_load_reg <= `RLDS_RST_BIT;
            rise_half_reg <= '0;
            fall_half_reg <= '0;
            hold_b_reg <= '0;
            primed_reg <= `RLDS_RST_BIT;
        end else begin
            pos_reg <= pos_next;
            rise_load_reg <= rise_load_next;
            pre_load_reg <= pre_load_next;
            rise_half_reg <= rise_half_next;
            fall_half_reg <= fall_half_next;
            hold_b_reg <= hold_b_next;
            primed_reg <= primed_next;
        end
    end

    // ==========================================
    // serializers: one per data pair in use, one for the link clock

    for (genvar k = 0; k < `RLDS_LANES_MAX; k++) begin : g_lane
        if (k < LANES) begin : g_on
            rlds_ser u_ser (
                .ser_clk_in(ser_clk_in),
                .ser_rst_n_in(rst_s2_reg),
                .rise_load_in(rise_load_reg),
                .rise_half_in(rise_half_reg[k]),
                .pre_load_180_in(pre_load_reg),
                .fall_half_in(fall_half_reg[k]),
                .ddr_out(lane_out[k])
            );
        end else begin : g_off
            // unused pair parks at a steady low differential level
            rlds_ddr_t idle_reg;
            always_ff @(posedge ser_clk_in) begin
                idle_reg <= '{pos_rise: `RLDS_IDLE_POS, pos_fall: `RLDS_IDLE_POS,
                              neg_rise: `RLDS_IDLE_NEG, neg_fall: `RLDS_IDLE_NEG};
            end
            assign lane_out[k] = idle_reg;
        end
    end

    // same ring and loads as the data pairs keep the clock locked to them
    rlds_ser u_clk_ser (
        .ser_clk_in(ser_clk_in),
        .ser_rst_n_in(rst_s2_reg),
        .rise_load_in(rise_load_reg),
        .rise_half_in(rise_half_reg[`RLDS_LANES_MAX]),
        .pre_load_180_in(pre_load_reg),
        .fall_half_in(fall_half_reg[`RLDS_LANES_MAX]),
        .ddr_out(link_clock_out)
    );

    // ==========================================
    // checks

    AST_XFER_STABLE: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (req_reg != ack_s2_reg) |=> $stable(xfer_reg))
        else $error("hand-over word moved while offered");

    AST_LATEST_HOLD: assert property (@(posedge ser_clk_in) disable iff (!rst_s2_reg)
        (req_s2_reg == req_s3_reg) |=> $stable(latest_reg))
        else $error("pixel word changed without a hand-over");

    AST_RING_ONEHOT: assert property (@(posedge ser_clk_in) disable iff (!rst_s2_reg)
        $onehot(pos_reg))
        else $error("bit position ring not one-hot");

    AST_RING_PERIOD: assert property (@(posedge ser_clk_in) disable iff (!rst_s2_reg)
        (pos_reg == POS_0) |=> (pos_reg != POS_0) [*6] ##1 (pos_reg == POS_0))
        else $error("ring period is not seven fast cycles");

    AST_CLK_FALL: assert property (@(posedge ser_clk_in) disable iff (!rst_s2_reg)
        (primed_reg && pos_reg == POS_1) |->
            (!link_clock_out.pos_rise && $past(link_clock_out.pos_fall)))
        else $error("link clock does not fall at bit 2");

    AST_CLK_RISE: assert property (@(posedge ser_clk_in) disable iff (!rst_s2_reg)
        (primed_reg && pos_reg == POS_2) |->
            (!link_clock_out.pos_rise && link_clock_out.pos_fall))
        else $error("link clock does not rise at bit 5");

    AST_CLK_SHAPE: assert property (@(posedge ser_clk_in) disable iff (!rst_s2_reg)
        (primed_reg && pos_reg == POS_0) |->
            (link_clock_out.pos_rise && link_clock_out.pos_fall)
            ##1 (!link_clock_out.pos_rise && !link_clock_out.pos_fall)
            ##1 (!link_clock_out.pos_rise && link_clock_out.pos_fall)
            ##1 (link_clock_out.pos_rise && link_clock_out.pos_fall)
            ##1 (link_clock_out.pos_rise && !link_clock_out.pos_fall)
            ##1 (!link_clock_out.pos_rise && !link_clock_out.pos_fall)
            ##1 (link_clock_out.pos_rise && link_clock_out.pos_fall))
        else $error("link clock waveform wrong over two pixels");

    AST_LANE_B0: assert property (@(posedge ser_clk_in) disable iff (!rst_s2_reg)
        (primed_reg && pos_reg == POS_3) |-> (lane_out[0].pos_fall == hold_b_reg[0][0]))
        else $error("second pixel bit 0 not on falling edge of cycle 3");

endmodule : rlds_tx

// ==== tb/rlds_rx_model.sv ====
`timescale 1ns/1ns

// ==========================================
// display receiver: rebuilds pixel slots from the ddr bit pairs
module rlds_rx_model #(
    parameter int LANES = 3
) (
    // serializer clock shared with the transmitter
    input wire logic ser_clk_in,
    // ddr data and regenerated clock from the transmitter
    input wire rlds_pkg::rlds_ddr_t [3:0] lane_in,
    input wire rlds_pkg::rlds_ddr_t link_clock_in,
    // last complete pixel slot and health counters
    output rlds_pkg::rlds_bank_t bank_out,
    output int frame_cnt_out,
    output int bad_cnt_out
);
    import rlds_pkg::*;

    rlds_bank_t shift_reg = '0;
    int gap_reg = 0;
    rlds_ddr_t [4:0] all_w;

    assign all_w = {link_clock_in, lane_in};

    initial begin
        bank_out = '0;
        frame_cnt_out = 0;
        bad_cnt_out = 0;
    end

    // ==========================================
    // slot boundary: clock bits high, high, low x3, high, high
    task automatic take_bits(input logic [4:0] bits);
        for (int l = 0; l < 5; l++) shift_reg[l] = {bits[l], shift_reg[l][6:1]};
        gap_reg++;
        if (shift_reg[4] === 7'h63) begin
            // first few slots after reset may be unprimed, so no gap check yet
            if (frame_cnt_out > 3 && gap_reg != 7) bad_cnt_out++;
            bank_out = shift_reg;
            frame_cnt_out++;
            gap_reg = 0;
        end
    endtask : take_bits

    // ==========================================
    // both flops of a cycle are settled at the rising edge that ends it
    always @(posedge ser_clk_in) begin
        logic [4:0] rise_b;
        logic [4:0] fall_b;
        for (int l = 0; l < 5; l++) begin
            rise_b[l] = all_w[l].pos_rise;
            fall_b[l] = all_w[l].pos_fall;
            if (frame_cnt_out > 3 &&
                {all_w[l].neg_rise, all_w[l].neg_fall} !== ~{rise_b[l], fall_b[l]}) begin
                bad_cnt_out++;
            end
            // the parked pair is unknown until its first fast edge, so judge it once locked
            if (frame_cnt_out > 3 && l >= LANES && l < 4 && all_w[l] !== 4'h3) begin
                bad_cnt_out++;
            end
        end
        take_bits(rise_b);
        take_bits(fall_b);
    end
endmodule : rlds_rx_model

// ==== tb/rlds_tb.sv ====
`timescale 1ns/1ns

module tb;
    import rlds_pkg::*;

    // ==========================================
    // clocks, reset, stimulus
    localparam int CYCLE_LIMIT = 5000;
    logic ref_clk_in = 1'b0;
    logic ser_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    rlds_pixel_t pixel_in = '0;
    int err_total = 0;
    int total_checks = 0;
    int cycle_cnt = 0;
    rlds_ddr_t [3:0] lane_out [2];
    rlds_ddr_t link_clock_out [2];
    rlds_bank_t bank [2];
    int frame_cnt [2];
    int bad_cnt [2];

    always #5 ref_clk_in = ~ref_clk_in;

    // offset keeps link edges off the pixel clock edges
    initial begin
        #2;
        // two bits per fast cycle stay far below the per-pair rate ceiling
        forever #15 ser_clk_in = ~ser_clk_in;
    end

    // ==========================================
    // one transmitter and receiver per colour depth
    for (genvar m = 0; m < 2; m++) begin : g_mode
        rlds_tx #(.LANES(3 + m)) rlds_tx_i (
            .ref_clk_in(ref_clk_in),
            .reset_n_in(reset_n_in),
            .pixel_in(pixel_in),
            .ser_clk_in(ser_clk_in),
            .lane_out(lane_out[m]),
            .link_clock_out(link_clock_out[m])
        );
        rlds_rx_model #(.LANES(3 + m)) rlds_rx_model_i (
            .ser_clk_in(ser_clk_in),
            .lane_in(lane_out[m]),
            .link_clock_in(link_clock_out[m]),
            .bank_out(bank[m]),
            .frame_cnt_out(frame_cnt[m]),
            .bad_cnt_out(bad_cnt[m])
        );
    end

    // ==========================================
    // checking and closing
    task automatic check_val(input logic [63:0] seen, input logic [63:0] expect_v);
        total_checks++;
        if (seen !== expect_v) begin
            err_total++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, expect_v);
        end
    endtask : check_val

    task automatic complete_run();
        if (err_total == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    always @(posedge ref_clk_in) begin
        cycle_cnt++;
        if (cycle_cnt == CYCLE_LIMIT) begin
            err_total++;
            complete_run();
        end
    end

    // slot words, bit 0 first; narrow mode leaves the fourth pair at zero
    function automatic rlds_bank_t expect_bank(input rlds_pixel_t p, input int lanes);
        rlds_bank_t b;
        b[0] = {p.green[0], p.red[5:0]};
        b[1] = {p.blue[1:0], p.green[5:1]};
        b[2] = {p.de, p.vsync, p.hsync, p.blue[5:2]};
        b[3] = (lanes == 4) ? {1'h0, p.blue[7:6], p.green[7:6], p.red[7:6]} : 7'h00;
        b[4] = 7'h63;
        return b;
    endfunction : expect_bank

    task automatic hold_pixel(input rlds_pixel_t p);
        @(posedge ref_clk_in);
        #1 pixel_in = p;
        // long hold: the hand-over may drop pixels, this one must get through
        repeat (150) @(posedge ref_clk_in);
    endtask : hold_pixel

    // ==========================================
    // scenarios
    task automatic test_reset_idle();
        for (int m = 0; m < 2; m++) begin
            for (int l = 0; l < 4; l++) check_val(64'(lane_out[m][l]), 64'h3);
            check_val(64'(link_clock_out[m]), 64'h3);
        end
    endtask : test_reset_idle

    task automatic test_pixel_map();
        rlds_pixel_t pats [6] = '{30'h3FFFFFFF, 30'h00000000, 30'h2AAAAAAA,
                                  30'h15555555, 30'h00000005, 30'h3C0C0C02};
        foreach (pats[i]) begin
            hold_pixel(pats[i]);
            for (int m = 0; m < 2; m++) begin
                check_val(64'(bank[m]), 64'(expect_bank(pats[i], 3 + m)));
            end
        end
    endtask : test_pixel_map

    task automatic test_link_timing();
        int f0 [2];
        @(posedge ser_clk_in);
        #1 f0 = frame_cnt;
        repeat (70) @(posedge ser_clk_in);
        #1;
        for (int m = 0; m < 2; m++) check_val(64'(frame_cnt[m] - f0[m]), 64'h14);
        check_val(64'(lane_out[0][3]), 64'h3);
    endtask : test_link_timing

    task automatic test_pixel_churn();
        rlds_bank_t sent_q [$];
        int last_f;
        int hit;
        int miss;
        int fresh;
        sent_q.push_back(expect_bank(pixel_in, 4));
        last_f = frame_cnt[1];
        miss = 0;
        fresh = 0;
        for (int k = 1; k <= 80; k++) begin
            @(posedge ref_clk_in);
            #1 pixel_in = rlds_pixel_t'(30'h01234567 * k);
            sent_q.push_back(expect_bank(pixel_in, 4));
            if (frame_cnt[1] != last_f) begin
                last_f = frame_cnt[1];
                hit = -1;
                foreach (sent_q[i]) if (sent_q[i] === bank[1]) hit = i;
                if (hit < 0) miss++;
                if (hit > 0) fresh++;
            end
        end
        check_val(64'(miss), 64'h0);
        check_val(64'(fresh > 0), 64'h1);
    endtask : test_pixel_churn

    // ==========================================
    // main sequence
    initial begin
        repeat (15) @(posedge ref_clk_in);
        #1 test_reset_idle();
        repeat (5) @(posedge ref_clk_in);
        #1 reset_n_in = 1'b1;
        test_pixel_map();
        test_link_timing();
        test_pixel_churn();
        for (int m = 0; m < 2; m++) check_val(64'(bad_cnt[m]), 64'h0);
        complete_run();
    end
endmodule : tb
